/* core/brake_hold_regs.svh */
// Timing counts and encodings for the braked hold state logic
`ifndef BRAKE_HOLD_REGS_SVH
`define BRAKE_HOLD_REGS_SVH
`define CLK_PERIOD_NS     4
`define ESC_STAGE_NS      1000
`define ESC_STAGE_CYC     (`ESC_STAGE_NS / `CLK_PERIOD_NS)
`define ST_RUN            3'h0
`define ST_BRK_STOP       3'h1
`define ST_BRK_ESTOP      3'h2
`define ST_BRK_HALT       3'h3
`define ST_BRK_STOP_PAR   3'h4
`define ST_BRK_STOP_ERR   3'h5
`define ESC_STAGES        3
`endif

/* core/brake_hold_pkg.sv */
// Types for the braked hold state logic
package brake_hold_pkg;
   typedef enum logic [2:0] {
      OP_RUN          = 3'h0,
      OP_BRK_STOP     = 3'h1,
      OP_BRK_ESTOP    = 3'h2,
      OP_BRK_HALT     = 3'h3,
      OP_BRK_STOP_PAR = 3'h4,
      OP_BRK_STOP_ERR = 3'h5
   } op_state_type;
   typedef enum logic [1:0] {
      ESC_IDLE = 2'h0,
      ESC_ONE  = 2'h1,
      ESC_TWO  = 2'h2,
      ESC_DONE = 2'h3
   } esc_state_type;
endpackage : brake_hold_pkg

/* core/error_escalation.sv */
// Staged error reaction sequencer
`timescale 1ns/1ps
`default_nettype none
`include "brake_hold_regs.svh"
module error_escalation
   import brake_hold_pkg::*;
(
   // Clock and reset
   input  wire logic     clk_in,
   input  wire logic     nrst_in,
   input  wire logic     ce_in,
   // Control
   input  wire logic     err_in,
   // Stage outputs
   output logic [1:0]    stage_out
);
   typedef struct packed {
      esc_state_type st;
      logic [7:0]    cnt;
   } esc_reg_type;
   localparam logic [7:0] STAGE_CYC = 8'(`ESC_STAGE_CYC - 1);
   esc_reg_type r, nxt;
   always_comb begin
      nxt = r;
      if (!err_in) begin
         nxt.st  = ESC_IDLE;
         nxt.cnt = 8'h00;
      end else begin
         unique case (r.st)
            ESC_IDLE: begin
               nxt.st  = ESC_ONE;
               nxt.cnt = 8'h00;
            end
            ESC_ONE, ESC_TWO: begin
               if (r.cnt == STAGE_CYC) begin
                  nxt.cnt = 8'h00;
                  nxt.st  = (r.st == ESC_ONE) ? ESC_TWO : ESC_DONE;
               end else begin
                  nxt.cnt = r.cnt + 8'h01;
               end
            end
            ESC_DONE: nxt.st = ESC_DONE;
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r <= '{ESC_IDLE, 8'h00};
      end else if (ce_in) begin
         r <= nxt;
      end
   end
   assign stage_out = r.st;
endmodule : error_escalation
`default_nettype wire

/* core/braked_hold_state_logic.sv */
// Braked hold operating state evaluation and brake drive
`timescale 1ns/1ps
`default_nettype none
`include "brake_hold_regs.svh"
module braked_hold_state_logic
   import brake_hold_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic       ce_in,
   // Pin inputs, asynchronous
   input  wire logic       supply_ok_in,
   input  wire logic       estop_switch_in,
   input  wire logic       redundant_fb_in,
   // Conditions from drive logic
   input  wire logic       motor_check_ok_in,
   input  wire logic       redundant_check_ok_in,
   input  wire logic       safe_standstill_sel_in,
   input  wire logic       motor_torque_ok_in,
   input  wire logic       redundant_torque_ok_in,
   input  wire logic       standstill_in,
   input  wire logic       restart_blocked_in,
   input  wire logic       halt_in,
   input  wire logic       param_mode_in,
   input  wire logic       error_in,
   input  wire logic       drive_enable_in,
   input  wire logic       ack_cond_in,
   // Outputs
   output logic [2:0]      op_state_out,
   output logic            safety_ack_out,
   output logic            motor_brake_apply_out,
   output logic            module_brake_apply_out,
   output logic            torque_off_out,
   output logic [1:0]      esc_stage_out
);
   typedef struct packed {
      logic [2:0]   sync1;
      logic [2:0]   sync2;
      op_state_type st;
      logic         ack;
      logic         mbrk;
      logic         rbrk;
      logic         toff;
      logic [1:0]   esc;
   } top_reg_type;

   top_reg_type  r, nxt;
   logic [1:0]   stage;
   logic         sup_ok, estop_sw, red_fb, conds_ok, fault;

   function automatic logic all_conds(input logic a, b, c, d, e, f, g);
      all_conds = a & b & c & d & e & f & g;
   endfunction : all_conds

   assign sup_ok   = r.sync2[0];
   assign estop_sw = r.sync2[1];
   assign red_fb   = r.sync2[2];
   // Stop variant conditions, shared by stop, estop, parameter and error variants
   // Estop switch alone counts as standstill selection
   assign conds_ok = all_conds(motor_check_ok_in, redundant_check_ok_in,
                               safe_standstill_sel_in | estop_sw,
                               motor_torque_ok_in,
                               redundant_torque_ok_in & red_fb,
                               standstill_in, restart_blocked_in);
   assign fault = error_in | ~sup_ok;

   error_escalation u_esc (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .ce_in     (ce_in),
      .err_in    (error_in),
      .stage_out (stage)
   );

   always_comb begin
      nxt       = r;
      nxt.sync1 = {redundant_fb_in, estop_switch_in, supply_ok_in};
      nxt.sync2 = r.sync1;
      nxt.esc   = stage;
      if (conds_ok && error_in) begin
         nxt.st = OP_BRK_STOP_ERR;
      end else if (conds_ok && param_mode_in) begin
         nxt.st = OP_BRK_STOP_PAR;
      end else if (conds_ok && estop_sw) begin
         nxt.st = OP_BRK_ESTOP;
      end else if (conds_ok) begin
         nxt.st = OP_BRK_STOP;
      end else if (halt_in) begin
         nxt.st = OP_BRK_HALT;
      end else begin
         nxt.st = OP_RUN;
      end
      // acknowledge in braked stop and estop
      unique case (nxt.st)
         OP_BRK_STOP, OP_BRK_ESTOP: nxt.ack = 1'b1;
         OP_BRK_STOP_PAR, OP_BRK_STOP_ERR: nxt.ack = ack_cond_in;
         OP_BRK_HALT, OP_RUN: nxt.ack = 1'b0;
      endcase
      nxt.mbrk = fault | halt_in | (nxt.st != OP_RUN);
      nxt.rbrk = nxt.mbrk;
      // drive enable holds torque during escalation
      nxt.toff = ~sup_ok | (error_in & (~drive_enable_in |
                 (stage == ESC_DONE)));
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         // Brakes applied at reset: safe default
         r <= '{3'h0, 3'h0, OP_RUN, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0};
      end else if (ce_in) begin
         r <= nxt;
      end
   end

   assign op_state_out           = r.st;
   assign safety_ack_out         = r.ack;
   assign motor_brake_apply_out  = r.mbrk;
   assign module_brake_apply_out = r.rbrk;
   assign torque_off_out         = r.toff;
   assign esc_stage_out          = r.esc;

   property p_supply_loss;
      @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && !sup_ok) |=> (motor_brake_apply_out &&
                              module_brake_apply_out);
   endproperty
   a_supply_loss: assert property (p_supply_loss)
      else $error("brakes not applied on supply loss");

   property p_err_brake;
      @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && error_in) |=> module_brake_apply_out;
   endproperty
   a_err_brake: assert property (p_err_brake)
      else $error("brakes not applied on error");

   property p_stop_ack;
      @(posedge clk_in) disable iff (!nrst_in)
      (op_state_out == OP_BRK_STOP) |-> safety_ack_out;
   endproperty
   a_stop_ack: assert property (p_stop_ack)
      else $error("no acknowledgement in braked stop");

   property p_halt_noack;
      @(posedge clk_in) disable iff (!nrst_in)
      (op_state_out == OP_BRK_HALT) |-> !safety_ack_out;
   endproperty
   a_halt_noack: assert property (p_halt_noack)
      else $error("acknowledgement in braked halt");

   property p_drop;
      @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && !conds_ok) |=> !(op_state_out inside
                               {OP_BRK_STOP, OP_BRK_ESTOP});
   endproperty
   a_drop: assert property (p_drop)
      else $error("braked stop held without conditions");

   property p_estop;
      @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && conds_ok && estop_sw && !error_in && !param_mode_in)
      |=> (op_state_out == OP_BRK_ESTOP);
   endproperty
   a_estop: assert property (p_estop)
      else $error("braked estop not entered");

   property p_halt;
      @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && halt_in && !conds_ok) |=>
         (op_state_out == OP_BRK_HALT && motor_brake_apply_out);
   endproperty
   a_halt: assert property (p_halt)
      else $error("braked halt not entered");

   property p_same_brakes;
      @(posedge clk_in) disable iff (!nrst_in)
      motor_brake_apply_out == module_brake_apply_out;
   endproperty
   a_same_brakes: assert property (p_same_brakes)
      else $error("brake commands differ");

   property p_stop;
      @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && conds_ok && !estop_sw && !error_in && !param_mode_in)
      |=> (op_state_out == OP_BRK_STOP && safety_ack_out);
   endproperty
   a_stop: assert property (p_stop)
      else $error("braked stop not entered");

   property p_param;
      @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && conds_ok && param_mode_in && !error_in)
      |=> (op_state_out == OP_BRK_STOP_PAR &&
           safety_ack_out == $past(ack_cond_in));
   endproperty
   a_param: assert property (p_param)
      else $error("parameter variant of braked stop wrong");

   sequence s_err_start;
      ce_in && error_in && stage == ESC_IDLE;
   endsequence
   property p_esc;
      @(posedge clk_in) disable iff (!nrst_in)
      s_err_start ##1 (ce_in && error_in) |-> stage == ESC_ONE;
   endproperty
   a_esc: assert property (p_esc)
      else $error("escalation did not start");
endmodule : braked_hold_state_logic
`default_nettype wire

/* tb/brake_module_model.sv */
// Redundant brake control module and machine controller model
`timescale 1ns/1ps
`default_nettype none
module brake_module_model #(
   parameter int LAG = 2
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   // Command and fault controls
   input  wire logic apply_in,
   input  wire logic fb_fault_in,
   input  wire logic enable_drop_in,
   // Status back
   output logic      fb_out,
   output logic      torque_out,
   output logic      enable_out
);
   logic [LAG-1:0] lag_r;
   // module applies brake
   // Torque builds slowly but is lost at once on release
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lag_r <= '0;
      end else begin
         lag_r <= {lag_r[LAG-2:0], apply_in};
      end
   end
   assign torque_out = &lag_r & apply_in;
   assign fb_out = ~fb_fault_in;
   assign enable_out = ~enable_drop_in;
endmodule : brake_module_model
`default_nettype wire

/* tb/test_braked_hold_state_logic.sv */
// Self-checking bench for the braked hold state logic
`timescale 1ns/1ps
`default_nettype none
`include "brake_hold_regs.svh"
module test_braked_hold_state_logic;
   localparam logic [11:0] SUP = 12'h001;
   localparam logic [11:0] ESW = 12'h002;
   localparam logic [11:0] SEL = 12'h010;
   localparam logic [11:0] HLT = 12'h100;
   localparam logic [11:0] PAR = 12'h200;
   localparam logic [11:0] ERR = 12'h400;
   localparam logic [11:0] ACK = 12'h800;
   localparam logic [11:0] ALL = 12'h0FC;
   logic        clk_in = 1'b0;
   logic        nrst_in = 1'b0;
   logic [11:0] c_r = 12'h000;
   logic        fault_r = 1'b0;
   logic        drop_r = 1'b0;
   logic [2:0]  state;
   logic [1:0]  esc;
   logic        ack, mbrk, rbrk, toff, fb, rtq, den;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   always #2 clk_in = ~clk_in;
   braked_hold_state_logic u_braked_hold_state_logic (
      .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
      .supply_ok_in(c_r[0]), .estop_switch_in(c_r[1]),
      .redundant_fb_in(fb), .motor_check_ok_in(c_r[2]),
      .redundant_check_ok_in(c_r[3]), .safe_standstill_sel_in(c_r[4]),
      .motor_torque_ok_in(c_r[5]), .redundant_torque_ok_in(rtq),
      .standstill_in(c_r[6]), .restart_blocked_in(c_r[7]),
      .halt_in(c_r[8]), .param_mode_in(c_r[9]), .error_in(c_r[10]),
      .drive_enable_in(den), .ack_cond_in(c_r[11]),
      .op_state_out(state), .safety_ack_out(ack),
      .motor_brake_apply_out(mbrk), .module_brake_apply_out(rbrk),
      .torque_off_out(toff), .esc_stage_out(esc)
   );
   brake_module_model u_brake_module_model (
      .clk_in(clk_in), .nrst_in(nrst_in), .apply_in(rbrk),
      .fb_fault_in(fault_r), .enable_drop_in(drop_r),
      .fb_out(fb), .torque_out(rtq), .enable_out(den)
   );
   task automatic compare(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare
   task automatic apply(input logic [11:0] v, input int n);
      @(posedge clk_in);
      c_r <= v;
      repeat (n) @(posedge clk_in);
      #1;
   endtask : apply
   task automatic look(input logic [2:0] s, input logic a,
                       input logic [1:0] b);
      compare({1'b0, state}, {1'b0, s});
      compare({3'h0, ack}, {3'h0, a});
      compare({2'h0, mbrk, rbrk}, {2'h0, b});
   endtask : look
   task automatic results;
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count++;
         results;
      end
   end
   initial begin
      repeat (8) @(posedge clk_in);
      nrst_in <= 1'b1;
      #1;
      look(`ST_RUN, 1'b0, 2'h3);
      apply(SUP, 6);
      look(`ST_RUN, 1'b0, 2'h0);
      compare({3'h0, toff}, 4'h0);
      @(posedge clk_in);
      drop_r <= 1'b1;
      // Enable dropped during an error: torque off at once
      apply(SUP | ERR, 3);
      compare({3'h0, toff}, 4'h1);
      @(posedge clk_in);
      drop_r <= 1'b0;
      apply(SUP | HLT, 6);
      look(`ST_BRK_HALT, 1'b0, 2'h3);
      apply(SUP | HLT | ALL, 6);
      look(`ST_BRK_STOP, 1'b1, 2'h3);
      // Each of the six conditions in bits 2 to 7 alone must break the braked stop
      for (int i = 2; i < 8; i++) begin
         apply(SUP | HLT | (ALL & ~(12'h001 << i)), 1);
         look(`ST_BRK_HALT, 1'b0, 2'h3);
         apply(SUP | HLT | ALL, 6);
         look(`ST_BRK_STOP, 1'b1, 2'h3);
      end
      @(posedge clk_in);
      fault_r <= 1'b1;
      apply(SUP | HLT | ALL, 4);
      look(`ST_BRK_HALT, 1'b0, 2'h3);
      @(posedge clk_in);
      fault_r <= 1'b0;
      apply(SUP | HLT | (ALL & ~SEL) | ESW, 6);
      compare({1'b0, state}, {1'b0, `ST_BRK_ESTOP});
      apply(SUP | HLT | ALL | PAR, 3);
      look(`ST_BRK_STOP_PAR, 1'b0, 2'h3);
      apply(SUP | HLT | ALL | PAR | ACK, 3);
      look(`ST_BRK_STOP_PAR, 1'b1, 2'h3);
      apply(SUP, 6);
      look(`ST_RUN, 1'b0, 2'h0);
      apply(12'h000, 3);
      compare({2'h0, mbrk, rbrk}, 4'h3);
      apply(SUP, 6);
      apply(SUP | ALL | ERR, 1);
      compare({2'h0, esc}, 4'h0);
      compare({2'h0, mbrk, rbrk}, 4'h3);
      repeat (`ESC_STAGE_CYC) @(posedge clk_in);
      #1;
      compare({2'h0, esc}, 4'h1);
      compare({3'h0, toff}, 4'h0);
      @(posedge clk_in);
      #1;
      compare({2'h0, esc}, 4'h2);
      repeat (`ESC_STAGE_CYC) @(posedge clk_in);
      #1;
      compare({2'h0, esc}, 4'h3);
      compare({3'h0, toff}, 4'h1);
      look(`ST_BRK_STOP_ERR, 1'b0, 2'h3);
      results;
   end
endmodule : test_braked_hold_state_logic
`default_nettype wire
